/* File: mad_bitmask.sv */
/*
  per byte mask of the bit positions that a bit-mode access really covers.
  assumes a zero based bit offset and a length counted in bits.
*/
`timescale 1ns/1ns
module mad_bitmask (
  input wire logic en,
  input wire logic [2:0] start,
  input wire logic [7:0] len,
  input wire logic [7:0] idx,
  output logic [7:0] mask
);
  // one compare pair per bit of the data byte
  for (genvar b = 0; b < 8; b++) begin : g_bit
    logic [10:0] pos;
    assign pos = {idx, 3'(b)};
    assign mask[b] = !en || (pos >= 11'(start) && pos < 11'(start) + 11'(len));
  end
endmodule

/* File: mad_codec.sv */
/*
  memory access datagram codec, target side: parses write requests into a
  header and a buffered data stream, and builds read replies.
  assumes the bus controller delivers each datagram as subfunction code then
  data field bytes, with last on the final byte, and that the application
  fetches and services every write itself.
*/
// Operation
// - A computer target uses byte 0 reserved, bytes 1-4 free, byte 5 length up to 128.
// - A computer target needs no address; the four address bytes are handed out as a tag.
// - A read reply carries subfunction code 1f hex.
// - An absolute read reply has byte 0 zero, address LSB first, length up to 128, data at 6.
// - An absolute read reply copies bytes 1 to 5 from the request unchanged.
// - A typed read reply has byte 0 zero, type, zero, offset low then high, length.
// - A memory write request carries subfunction code 20 hex.
// - A plain typed write holds length in units, at most 128 bits, 128 bytes or 64 words.
// - A program write has type 4, name in 5-12, length up to 64 words in 13, data at 14.
// - A local block write has type 0, names in 5-12 and 13-20, length in 21, data at 22.
// - Bit mode reads return zero in unused bits and writes ignore unused bits.
// - Memory offsets count from zero.
`timescale 1ns/1ns
module mad_codec import mad_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire mad_byte_type rx_byte,
  output logic rx_ready,
  input wire mad_fmt_type wr_fmt,
  input wire mad_unit_type wr_unit,
  output mad_whdr_type wr_hdr,
  output logic wr_hdr_valid,
  output logic wr_done,
  output logic wr_malformed,
  output logic wd_valid,
  output mad_byte_type wd_byte,
  input wire logic wd_ready,
  input wire logic rr_start,
  input wire mad_rreq_type rr_req,
  output logic rr_busy,
  output logic rr_refused,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output logic rd_ready,
  output logic tx_valid,
  output mad_byte_type tx_byte,
  input wire logic tx_ready
);
  typedef enum logic [1:0] {RX_SUBFN, RX_HDR, RX_DATA, RX_DROP} mad_rx_type;
  typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_DATA} mad_tx_type;

  mad_rx_type rx_state, next_rx_state;
  logic [4:0] idx, next_idx;
  logic [8:0] remain, next_remain;
  logic [7:0] dpos, next_dpos;
  logic mine, next_mine, err, next_err;
  mad_whdr_type next_wr_hdr;
  logic next_hdr_valid, next_done, next_malformed;
  logic take, push, exceed;
  logic [4:0] len_pos;
  logic [7:0] rmask;
  mad_byte_type push_word;

  // data bytes of a write wait here until the application takes them
  mad_fifo #(
    .WIDTH($bits(mad_byte_type)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push),
    .in_data(push_word),
    .in_ready(rx_ready),
    .out_valid(wd_valid),
    .out_data(wd_byte),
    .out_ready(wd_ready)
  );

  mad_bitmask u_rx_mask (
    .en(wr_hdr.unit == UNIT_BIT),
    .start(wr_hdr.offset[2:0]),
    .len(wr_hdr.len),
    .idx(dpos),
    .mask(rmask)
  );

  // where the length byte sits for the captured format
  always_comb begin
    len_pos = POS_LEN_STD;
    if (wr_hdr.fmt == FMT_TYPED && wr_hdr.mem_type == MTYPE_PROG) begin
      len_pos = POS_LEN_PROG;
    end else if (wr_hdr.fmt == FMT_TYPED && wr_hdr.mem_type == MTYPE_LOCAL) begin
      len_pos = POS_LEN_LOCAL;
    end
  end

  // write request parser
  always_comb begin
    logic [4:0] k;
    k = 5'h00;
    take = rx_valid && rx_ready;
    next_rx_state = rx_state;
    next_idx = idx;
    next_remain = remain;
    next_dpos = dpos;
    next_mine = mine;
    next_err = err;
    next_wr_hdr = wr_hdr;
    next_hdr_valid = 1'b0;
    next_done = 1'b0;
    next_malformed = 1'b0;
    exceed = rx_byte.data > max_len(wr_hdr.fmt, wr_hdr.mem_type, wr_hdr.unit);
    push = 1'b0;
    push_word.data = rx_byte.data & rmask;
    push_word.last = rx_byte.last || remain == 9'h001;
    case (rx_state)
      RX_SUBFN: begin
        if (take && !rx_byte.last) begin
          next_idx = 5'h00;
          next_err = 1'b0;
          next_dpos = 8'h00;
          next_mine = rx_byte.data == SUBFN_WRITE;
          next_rx_state = next_mine ? RX_HDR : RX_DROP;
          next_wr_hdr = '0;
          next_wr_hdr.fmt = wr_fmt;
          next_wr_hdr.unit = wr_fmt == FMT_TYPED ? wr_unit : UNIT_BYTE;
        end
      end
      RX_HDR: begin
        if (take) begin
          next_idx = idx + 5'h01;
          case (idx)
            5'h01: begin
              next_wr_hdr.tag[7:0] = rx_byte.data;
              next_wr_hdr.mem_type = rx_byte.data;
              if (wr_hdr.fmt == FMT_TYPED &&
                  (rx_byte.data == MTYPE_PROG || rx_byte.data == MTYPE_LOCAL)) begin
                next_wr_hdr.unit = UNIT_WORD;
              end
            end
            5'h02: next_wr_hdr.tag[15:8] = rx_byte.data;
            5'h03: begin
              next_wr_hdr.tag[23:16] = rx_byte.data;
              next_wr_hdr.offset[7:0] = rx_byte.data;
            end
            5'h04: begin
              next_wr_hdr.tag[31:24] = rx_byte.data;
              next_wr_hdr.offset[15:8] = rx_byte.data;
            end
            default: begin
              if (idx < len_pos && idx < POS_BNAME) begin
                k = idx - POS_PNAME;
                next_wr_hdr.pname[k[2:0]*8 +: 8] = rx_byte.data;
              end else if (idx < len_pos) begin
                k = idx - POS_BNAME;
                next_wr_hdr.bname[k[2:0]*8 +: 8] = rx_byte.data;
              end
            end
          endcase
          if (idx == len_pos) begin
            next_wr_hdr.len = rx_byte.data;
            next_remain = data_bytes(wr_hdr.unit, rx_byte.data, wr_hdr.offset[2:0]);
            if (exceed) begin
              next_err = 1'b1;
              next_rx_state = RX_DROP;
            end else begin
              next_hdr_valid = 1'b1;
              next_rx_state = next_remain == 9'h000 ? RX_DROP : RX_DATA;
            end
          end
        end
      end
      RX_DATA: begin
        if (take) begin
          push = 1'b1;
          next_remain = remain - 9'h001;
          next_dpos = dpos + 8'h01;
          if (remain == 9'h001) begin
            next_rx_state = RX_DROP;
          end
        end
      end
      RX_DROP: begin
        if (take && mine) begin
          next_err = 1'b1; // bytes past the counted data
        end
      end
      default: next_rx_state = RX_SUBFN;
    endcase
    // frame end: complete only if the data ran out exactly here
    if (take && rx_byte.last && rx_state != RX_SUBFN) begin
      next_rx_state = RX_SUBFN;
      if (mine) begin
        next_done = (rx_state == RX_DATA && remain == 9'h001 && !next_err) ||
                    (rx_state == RX_HDR && idx == len_pos && !exceed &&
                     next_remain == 9'h000);
        next_malformed = !next_done;
      end
      next_mine = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_state <= RX_SUBFN;
      idx <= 5'h00;
      remain <= 9'h000;
      dpos <= 8'h00;
      mine <= 1'b0;
      err <= 1'b0;
      wr_hdr <= '0;
      wr_hdr_valid <= 1'b0;
      wr_done <= 1'b0;
      wr_malformed <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      idx <= next_idx;
      remain <= next_remain;
      dpos <= next_dpos;
      mine <= next_mine;
      err <= next_err;
      wr_hdr <= next_wr_hdr;
      wr_hdr_valid <= next_hdr_valid;
      wr_done <= next_done;
      wr_malformed <= next_malformed;
    end
  end

  mad_tx_type tx_state, next_tx_state;
  mad_rreq_type req, next_req;
  logic [2:0] tidx, next_tidx;
  logic [8:0] tcnt, next_tcnt;
  logic [7:0] tpos, next_tpos, tmask;
  logic next_tx_valid, next_rd_ready, next_busy, next_refused, slot;
  mad_byte_type next_tx_byte;

  mad_bitmask u_tx_mask (
    .en(req.unit == UNIT_BIT),
    .start(req.tag[18:16]),
    .len(req.len),
    .idx(tpos),
    .mask(tmask)
  );

  // read reply builder
  always_comb begin
    slot = !tx_valid || tx_ready;
    next_tx_state = tx_state;
    next_req = req;
    next_tidx = tidx;
    next_tcnt = tcnt;
    next_tpos = tpos;
    next_refused = 1'b0;
    next_tx_valid = tx_valid && !tx_ready;
    next_tx_byte = tx_byte;
    case (tx_state)
      TX_IDLE: begin
        if (rr_start) begin
          if (rr_req.len > max_len(rr_req.fmt, rr_req.tag[7:0], rr_req.unit)) begin
            next_refused = 1'b1;
          end else begin
            next_req = rr_req;
            next_tidx = 3'h0;
            next_tpos = 8'h00;
            next_tx_state = TX_HDR;
          end
        end
      end
      TX_HDR: begin
        if (slot) begin
          next_tx_valid = 1'b1;
          next_tx_byte.last = 1'b0;
          next_tidx = tidx + 3'h1;
          case (tidx)
            3'h0: next_tx_byte.data = SUBFN_READ_REPLY;
            3'h1: next_tx_byte.data = 8'h00;
            3'h2: next_tx_byte.data = req.tag[7:0];
            3'h3: next_tx_byte.data = req.fmt == FMT_TYPED ? 8'h00 : req.tag[15:8];
            3'h4: next_tx_byte.data = req.tag[23:16];
            3'h5: next_tx_byte.data = req.tag[31:24];
            default: next_tx_byte.data = req.len;
          endcase
          if (tidx == TX_POS_LEN) begin
            next_tcnt = data_bytes(req.unit, req.len, req.tag[18:16]);
            next_tx_byte.last = next_tcnt == 9'h000;
            next_tx_state = next_tcnt == 9'h000 ? TX_IDLE : TX_DATA;
          end
        end
      end
      TX_DATA: begin
        if (rd_valid && rd_ready) begin
          next_tx_valid = 1'b1;
          next_tx_byte.data = rd_data & tmask;
          next_tx_byte.last = tcnt == 9'h001;
          next_tcnt = tcnt - 9'h001;
          next_tpos = tpos + 8'h01;
          if (tcnt == 9'h001) begin
            next_tx_state = TX_IDLE;
          end
        end
      end
      default: next_tx_state = TX_IDLE;
    endcase
    // application data is taken only into an empty output stage
    next_rd_ready = next_tx_state == TX_DATA && !next_tx_valid;
    next_busy = next_tx_state != TX_IDLE || next_tx_valid;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_state <= TX_IDLE;
      req <= '0;
      tidx <= 3'h0;
      tcnt <= 9'h000;
      tpos <= 8'h00;
      tx_valid <= 1'b0;
      tx_byte <= '0;
      rd_ready <= 1'b0;
      rr_busy <= 1'b0;
      rr_refused <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      req <= next_req;
      tidx <= next_tidx;
      tcnt <= next_tcnt;
      tpos <= next_tpos;
      tx_valid <= next_tx_valid;
      tx_byte <= next_tx_byte;
      rd_ready <= next_rd_ready;
      rr_busy <= next_busy;
      rr_refused <= next_refused;
    end
  end

  // checks beside the logic they guard
  property p_reply_code;
    @(posedge clk) disable iff (rst)
    (tx_state == TX_HDR && tidx == 3'h0 && slot) |=> tx_valid && tx_byte.data == 8'h1f;
  endproperty
  a_reply_code: assert property (p_reply_code) else $error("reply code wrong");

  property p_zero_byte0;
    @(posedge clk) disable iff (rst)
    (tx_state == TX_HDR && tidx == 3'h1 && slot) |=> tx_byte.data == 8'h00;
  endproperty
  a_zero_byte0: assert property (p_zero_byte0) else $error("reply byte 0 not zero");

  property p_copy_addr;
    @(posedge clk) disable iff (rst)
    (tx_state == TX_HDR && tidx == 3'h5 && slot) |=> tx_byte.data == $past(req.tag[31:24]);
  endproperty
  a_copy_addr: assert property (p_copy_addr) else $error("address byte not copied");

  property p_typed_zero;
    @(posedge clk) disable iff (rst)
    (tx_state == TX_HDR && tidx == 3'h3 && slot && req.fmt == FMT_TYPED)
      |=> tx_byte.data == 8'h00;
  endproperty
  a_typed_zero: assert property (p_typed_zero) else $error("typed byte 2 not zero");

  property p_refuse_long;
    @(posedge clk) disable iff (rst)
    (tx_state == TX_IDLE && rr_start && rr_req.fmt == FMT_COMPUTER && rr_req.len > 8'h80)
      |=> rr_refused && !rr_busy ##1 !tx_valid;
  endproperty
  a_refuse_long: assert property (p_refuse_long) else $error("long reply not refused");

  property p_write_code;
    @(posedge clk) disable iff (rst)
    (rx_state == RX_SUBFN && take && !rx_byte.last && rx_byte.data != 8'h20)
      |=> rx_state == RX_DROP && !wr_hdr_valid;
  endproperty
  a_write_code: assert property (p_write_code) else $error("foreign code parsed");

  property p_no_process;
    @(posedge clk) disable iff (rst)
    (rx_state == RX_HDR && take && idx == len_pos && exceed && !rx_byte.last)
      |=> !wr_hdr_valid && rx_state != RX_DATA ##1 rx_state != RX_DATA;
  endproperty
  a_no_process: assert property (p_no_process) else $error("oversize write processed");

  property p_prog_len;
    @(posedge clk) disable iff (rst)
    (rx_state == RX_HDR && take && idx == 5'h0d && wr_hdr.fmt == FMT_TYPED &&
     wr_hdr.mem_type == 8'h04 && rx_byte.data <= 8'h40)
      |=> wr_hdr_valid && wr_hdr.len == $past(rx_byte.data);
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("program length misplaced");

  property p_local_len;
    @(posedge clk) disable iff (rst)
    (rx_state == RX_HDR && take && idx == 5'h0d && wr_hdr.fmt == FMT_TYPED &&
     wr_hdr.mem_type == 8'h00) |=> !wr_hdr_valid && wr_hdr.bname[7:0] == $past(rx_byte.data);
  endproperty
  a_local_len: assert property (p_local_len) else $error("block name misplaced");
endmodule

/* File: mad_cpu_model.sv */
/*
  remote cpu stand-in: offers datagram bytes on the receive stream and
  takes reply bytes, with optional stalls. assumes the bench fills txq.
*/
`timescale 1ns/1ns
module mad_cpu_model import mad_pkg::*; (
  input wire logic clk,
  output logic rx_valid = 1'b0,
  output mad_byte_type rx_byte = '0,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire mad_byte_type tx_byte,
  output logic tx_ready = 1'b0
);
  mad_byte_type txq[$];
  mad_byte_type got[$];
  bit tk = 0;
  bit slow = 0;

  // byte taken or reply byte collected at the rising edge
  always @(posedge clk) begin
    tk <= rx_valid && rx_ready;
    if (tx_valid && tx_ready) got.push_back(tx_byte);
  end

  // byte held until taken; an idle line keeps toggling
  always @(negedge clk) begin
    if (tk) void'(txq.pop_front());
    rx_valid = txq.size() > 0;
    rx_byte = rx_valid ? txq[0] : ~rx_byte;
    tx_ready = !slow || ($urandom % 3 == 0);
  end
endmodule

/* File: mad_fifo.sv */
/*
  synchronous fifo with registered read data and valid/ready on both sides.
  assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/1ns
module mad_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_check
    $error("mad_fifo DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic next_in_ready, next_out_valid, push, pop;
  logic [WIDTH-1:0] next_out_data;

  // pointers, fill count and output stage
  always_comb begin
    push = in_valid && in_ready;
    pop = (cnt != '0) && (!out_valid || out_ready);
    next_wp = wp + AW'(push);
    next_rp = rp + AW'(pop);
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
    next_in_ready = next_cnt < (AW+1)'(DEPTH); // honest full
    next_out_data = pop ? mem[rp] : out_data;
    next_out_valid = pop ? 1'b1 : (out_ready ? 1'b0 : out_valid);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
      in_ready <= next_in_ready;
      out_valid <= next_out_valid;
      out_data <= next_out_data;
    end
  end

  // storage array
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
endmodule

/* File: mad_pkg.sv */
/*
  shared constants, field positions, enums and carriers for the memory
  access datagram codec. assumes a byte-wide datagram stream after the
  bus controller has stripped its own framing.
*/
package mad_pkg;
  // subfunction codes
  localparam logic [7:0] SUBFN_READ_REPLY = 8'h1f;
  localparam logic [7:0] SUBFN_WRITE = 8'h20;
  // length limits per datagram
  localparam logic [7:0] MAX_BYTE_LEN = 8'h80;
  localparam logic [7:0] MAX_WORD_LEN = 8'h40;
  // memory types with embedded names
  localparam logic [7:0] MTYPE_PROG = 8'h04;
  localparam logic [7:0] MTYPE_LOCAL = 8'h00;
  // byte positions inside the data field (TX_POS_LEN counts from the subfunction code), and the fifo depth
  localparam logic [4:0] POS_LEN_STD = 5'h05;
  localparam logic [4:0] POS_LEN_PROG = 5'h0d;
  localparam logic [4:0] POS_LEN_LOCAL = 5'h15;
  localparam logic [4:0] POS_PNAME = 5'h05;
  localparam logic [4:0] POS_BNAME = 5'h0d;
  localparam logic [2:0] TX_POS_LEN = 3'h6;
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [1:0] {FMT_COMPUTER, FMT_ABSOLUTE, FMT_TYPED} mad_fmt_type;
  typedef enum logic [1:0] {UNIT_BYTE, UNIT_BIT, UNIT_WORD} mad_unit_type;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } mad_byte_type;

  typedef struct packed {
    mad_fmt_type fmt;
    mad_unit_type unit;
    logic [7:0] mem_type;
    logic [15:0] offset;
    logic [31:0] tag;
    logic [7:0] len;
    logic [63:0] pname;
    logic [63:0] bname;
  } mad_whdr_type;

  typedef struct packed {
    mad_fmt_type fmt;
    mad_unit_type unit;
    logic [31:0] tag;
    logic [7:0] len;
  } mad_rreq_type;

  // longest length field allowed for a format
  function automatic logic [7:0] max_len(mad_fmt_type fmt, logic [7:0] mtype,
                                         mad_unit_type unit);
    if (fmt == FMT_TYPED && (unit == UNIT_WORD || mtype == MTYPE_PROG ||
                             mtype == MTYPE_LOCAL))
      return MAX_WORD_LEN;
    return MAX_BYTE_LEN;
  endfunction

  // data bytes carried for a length in the given unit
  function automatic logic [8:0] data_bytes(mad_unit_type unit, logic [7:0] len,
                                            logic [2:0] start);
    logic [9:0] bits;
    bits = 10'(start) + 10'(len) + 10'h007;
    case (unit)
      UNIT_BIT: return bits[9:3] == 7'h00 ? 9'h000 : 9'(bits[9:3]);
      UNIT_WORD: return {len, 1'b0};
      default: return 9'(len);
    endcase
  endfunction
endpackage

/* File: memory_access_datagram_codec_test.sv */
/*
  bench for the datagram codec with a queue model of fields and data.
  assumes the codec, fifo and remote cpu model files.
*/
`timescale 1ns/1ns
module memory_access_datagram_codec_test import mad_pkg::*;;
  logic clk = 0;
  logic rst = 1;
  logic wd_ready = 0;
  logic rr_start = 0;
  logic rd_valid = 0;
  logic [7:0] rd_data = 8'h00;
  mad_fmt_type wr_fmt = FMT_COMPUTER;
  mad_unit_type wr_unit = UNIT_BYTE;
  mad_rreq_type rr_req = '0;
  logic rx_valid, rx_ready, tx_valid, tx_ready, wr_hdr_valid, wr_done, wr_malformed;
  logic wd_valid, rr_busy, rr_refused, rd_ready;
  mad_byte_type rx_byte, wd_byte, tx_byte;
  mad_whdr_type wr_hdr, hdr;
  int error_cnt = 0;
  int comparisons = 0;
  int n_done = 0;
  int n_mal = 0;
  int n_ref = 0;
  int n_hdr = 0;
  bit hold = 0;
  bit rd_tk = 0;
  logic [7:0] hq[$], rdq[$], exq[$];
  mad_byte_type wq[$];
  int ln[5] = '{128, 64, 12, 65, 129};
  mad_unit_type us[5] = '{UNIT_BYTE, UNIT_WORD, UNIT_BIT, UNIT_WORD, UNIT_BIT};

  always #4 clk = ~clk;

  mad_codec #(.DEPTH(FIFO_DEPTH)) i_dut (.clk, .rst, .rx_valid, .rx_byte, .rx_ready, .wr_fmt,
    .wr_unit, .wr_hdr, .wr_hdr_valid, .wr_done, .wr_malformed, .wd_valid, .wd_byte, .wd_ready,
    .rr_start, .rr_req, .rr_busy, .rr_refused, .rd_valid, .rd_data, .rd_ready, .tx_valid,
    .tx_byte, .tx_ready);
  mad_cpu_model i_cpu (.clk, .rx_valid, .rx_byte, .rx_ready, .tx_valid, .tx_byte, .tx_ready);

  // outputs collected at the rising edge
  always @(posedge clk) begin
    rd_tk <= rd_valid && rd_ready;
    if (wd_valid && wd_ready) wq.push_back(wd_byte);
    if (wr_done) n_done++;
    if (wr_malformed) n_mal++;
    if (rr_refused) n_ref++;
    if (wr_hdr_valid) n_hdr++;
    if (wr_hdr_valid) hdr <= wr_hdr;
  end

  // application side: reply data offered, write data fetched with stalls
  always @(negedge clk) begin
    if (rd_tk) void'(rdq.pop_front());
    rd_valid = rdq.size() > 0;
    rd_data = rd_valid ? rdq[0] : ~rd_data;
    wd_ready = !hold && ($urandom % 4 != 0);
  end

  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic test_done;
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // mask of covered bits in data byte i
  function automatic logic [7:0] bmask(int s, int l, int i);
    for (int p = 0; p < 8; p++) bmask[p] = (8 * i + p >= s) && (8 * i + p < s + l);
  endfunction

  function automatic logic [63:0] pk(int at);
    for (int i = 0; i < 8; i++) pk[8 * i +: 8] = hq[at + i];
  endfunction

  // name padded with nulls, eighth place always null
  task automatic nm(string s);
    for (int i = 0; i < 8; i++) hq.push_back(i < 7 && i < s.len() ? s[i] : 8'h00);
  endtask

  // data byte count for a length in its unit
  function automatic int nbytes(mad_unit_type u, int s, int l);
    return u == UNIT_BIT ? (s + l + 7) / 8 : u == UNIT_WORD ? 2 * l : l;
  endfunction

  // one write datagram: header hq, nd data bytes, then outcome checks
  task automatic run_wr(input logic [7:0] sub, input mad_fmt_type f, input mad_unit_type u,
      input int nd, input bit ok);
    int d0, m0, w0, h0, k;
    logic [7:0] b;
    mad_byte_type q[$];
    mad_unit_type eu;
    d0 = n_done;
    m0 = n_mal;
    w0 = wq.size();
    h0 = n_hdr;
    exq = {};
    wr_fmt = f;
    wr_unit = u;
    eu = f != FMT_TYPED ? UNIT_BYTE : (hq[1] == MTYPE_PROG || hq[1] == MTYPE_LOCAL) ? UNIT_WORD : u;
    q.push_back({1'b0, sub});
    foreach (hq[i]) q.push_back({1'b0, hq[i]});
    for (int i = 0; i < nd; i++) begin
      b = 8'($urandom);
      q.push_back({1'b0, b});
      exq.push_back(eu == UNIT_BIT ? b & bmask(hq[3][2:0], hq[5], i) : b);
    end
    q[q.size() - 1].last = 1'b1;
    foreach (q[i]) i_cpu.txq.push_back(q[i]);
    for (k = 0; k < 3000 && (i_cpu.txq.size() > 0 || wq.size() < w0 + (ok ? nd : 0)); k++)
      @(negedge clk);
    chk("time", k < 3000, 1);
    repeat (4) @(negedge clk);
    chk("done", n_done - d0, ok);
    chk("hdr", n_hdr - h0, ok);
    chk("malformed", n_mal - m0, sub == SUBFN_WRITE && !ok);
    chk("count", wq.size() - w0, ok ? nd : 0);
    if (ok) begin
      foreach (exq[i]) chk("data", wq[w0 + i].data, exq[i]);
      chk("last", wq[wq.size() - 1].last, 1);
      chk("len", hdr.len, hq[hq.size() - 1]);
      chk("tag", hdr.tag, {hq[4], hq[3], hq[2], hq[1]});
      chk("fmt", {hdr.fmt, hdr.unit}, {f, eu});
      if (f == FMT_TYPED) chk("off", {hdr.mem_type, hdr.offset}, {hq[1], hq[4], hq[3]});
    end
  endtask

  // one read reply built from t and l, checked byte for byte on the stream
  task automatic run_rd(input mad_fmt_type f, input mad_unit_type u, input logic [31:0] t,
      input logic [7:0] l, input bit ok);
    int g0, r0, k;
    logic [7:0] b;
    g0 = i_cpu.got.size();
    r0 = n_ref;
    exq = {SUBFN_READ_REPLY, 8'h00};
    for (int i = 0; i < 4; i++) exq.push_back(f == FMT_TYPED && i == 1 ? 8'h00 : t[8 * i +: 8]);
    exq.push_back(l);
    for (int i = 0; ok && i < nbytes(u, t[18:16], l); i++) begin
      b = 8'($urandom);
      rdq.push_back(b);
      exq.push_back(u == UNIT_BIT ? b & bmask(t[18:16], l, i) : b);
    end
    for (k = 0; k < 500 && rr_busy !== 1'b0; k++) @(negedge clk);
    rr_req = '{fmt: f, unit: u, tag: t, len: l};
    rr_start = 1;
    @(negedge clk);
    rr_start = 0;
    for (k = 0; k < 3000 && i_cpu.got.size() < g0 + exq.size() && n_ref == r0; k++)
      @(negedge clk);
    chk("time", k < 3000, 1);
    repeat (4) @(negedge clk);
    chk("refused", n_ref - r0, !ok);
    chk("reply count", i_cpu.got.size() - g0, ok ? exq.size() : 0);
    for (int i = 0; ok && i < exq.size(); i++)
      chk("reply", i_cpu.got[g0 + i], {i == exq.size() - 1, exq[i]});
  endtask

  initial begin
    void'($urandom(32'h0fa8));
    repeat (4) @(negedge clk);
    chk("reset", {rx_ready, wd_valid, tx_valid, rr_busy}, 0);
    rst = 0;
    @(negedge clk);
    // two parts of one group at the largest length, first one stalled
    for (int p = 1; p < 3; p++) begin
      hq = {8'h00, 8'(p), 8'h01, 8'h00, 8'h00, 8'd128};
      hold = p == 1;
      fork
        run_wr(SUBFN_WRITE, FMT_COMPUTER, UNIT_BYTE, 128, 1);
        if (hold) begin
          repeat (300) @(negedge clk);
          chk("full", {rx_ready, wd_valid}, 2'b01);
          hold = 0;
        end
      join
    end
    hq = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'd129};
    run_wr(SUBFN_WRITE, FMT_COMPUTER, UNIT_BYTE, 2, 0);
    run_wr(SUBFN_READ_REPLY, FMT_COMPUTER, UNIT_BYTE, 2, 0);
    hq = {8'h00, 8'h34, 8'h12, 8'h00, 8'h80, 8'd5};
    run_wr(SUBFN_WRITE, FMT_ABSOLUTE, UNIT_BYTE, 5, 1);
    for (int j = 0; j < 5; j++) begin
      hq = {8'h00, 8'h08, 8'h00, 8'(j * 3), 8'h01, 8'(ln[j])};
      run_wr(SUBFN_WRITE, FMT_TYPED, us[j], j < 3 ? nbytes(us[j], j * 3, ln[j]) : 2, j < 3);
    end
    hq = {8'h00, MTYPE_PROG, 8'h00, 8'h07, 8'h00};
    nm("MAIN");
    hq.push_back(8'd64);
    run_wr(SUBFN_WRITE, FMT_TYPED, UNIT_BYTE, 128, 1);
    chk("pname", hdr.pname, pk(5));
    hq[13] = 8'd65;
    run_wr(SUBFN_WRITE, FMT_TYPED, UNIT_BYTE, 2, 0);
    hq = {8'h00, MTYPE_LOCAL, 8'h00, 8'h00, 8'h00};
    nm("MAIN");
    nm("BLK1");
    hq.push_back(8'd3);
    run_wr(SUBFN_WRITE, FMT_TYPED, UNIT_BYTE, 6, 1);
    chk("pname", hdr.pname, pk(5));
    chk("bname", hdr.bname, pk(13));
    run_rd(FMT_ABSOLUTE, UNIT_BYTE, 32'h8040_2010, 8'd4, 1);
    i_cpu.slow = 1;
    run_rd(FMT_TYPED, UNIT_WORD, 32'h0012_ff08, 8'd2, 1);
    run_rd(FMT_TYPED, UNIT_BIT, 32'h0003_0046, 8'd3, 1);
    run_rd(FMT_COMPUTER, UNIT_BYTE, 32'h0, 8'd129, 0);
    run_rd(FMT_TYPED, UNIT_WORD, 32'h0000_0008, 8'd65, 0);
    test_done;
  end

  // hang guard
  initial begin
    #600000;
    error_cnt++;
    test_done;
  end
endmodule
